// ---- common/port_io_consts.svh ----
`ifndef PORT_IO_CONSTS_SVH
`define PORT_IO_CONSTS_SVH

// pin and function counts
`define PIO_NUM_PINS        33
`define PIO_NUM_SLOTS       26
`define PIO_PIN_MASK        40'h01_FFFF_FFFF

// register byte offsets
`define PIO_PORT_LAST       3'h4
`define PIO_SEL_A_ADDR      12'h050
`define PIO_SEL_B_ADDR      12'h054
`define PIO_SEL_C_ADDR      12'h058
`define PIO_CTRL_ADDR       12'h05C

// control register fields
`define PIO_CTRL_XBAR_BIT   0
`define PIO_CTRL_PUD_BIT    1

// reset values
`define PIO_LATCH_RST       40'hFF_FFFF_FFFF
`define PIO_IN_MODE_RST     40'hFF_FFFF_FFFF
`define PIO_OUT_MODE_RST    40'h00_0000_0000
`define PIO_SKIP_RST        40'h00_0000_0000
`define PIO_SEL_RST         8'h00
`define PIO_CTRL_RST        2'h0

// fixed pins
`define PIO_VREF_PIN        0
`define PIO_XTAL_IN_PIN     2
`define PIO_OSC_OUT_PIN     3
`define PIO_FIXED_BASE_PIN  4
`define PIO_DEBUG_PIN       32

// function slots in priority order; slots 0..3 sit on fixed pins
`define PIO_SLOT_UART       0
`define PIO_SLOT_CAN        2
`define PIO_SLOT_FLEX       4
`define PIO_SLOT_SPI        4
`define PIO_SLOT_SMB        8
`define PIO_SLOT_CMP        10
`define PIO_SLOT_PCA        15
`define PIO_PCA_CHANNELS    6
`define PIO_SLOT_ECI        21
`define PIO_SLOT_T0         22
`define PIO_SLOT_T1         23
`define PIO_SLOT_LIN        24

// axi responses
`define PIO_RESP_OKAY       2'h0
`define PIO_RESP_SLVERR     2'h2

`endif

// ---- common/port_io_pkg.sv ----
package port_io_pkg;

    typedef logic [4:0] slot_t;

    typedef enum logic [1:0] {
        KIND_LATCH,
        KIND_IN_MODE,
        KIND_OUT_MODE,
        KIND_SKIP
    } reg_kind_t;

endpackage : port_io_pkg

// ---- core/port_io_cell.sv ----
`timescale 1ns/1ns
`default_nettype none

module port_io_cell (
    // configuration
    input  wire logic digital_mode,
    input  wire logic push_pull,
    input  wire logic crossbar_enable,
    input  wire logic pullup_global_disable,
    input  wire logic release_pad,
    // value to drive
    input  wire logic out_val,
    // pad side
    input  wire logic pad_i,
    output logic      pad_o,
    output logic      pad_oe_n,
    output logic      pullup_on,
    // read back
    output logic      read_val
);

    logic drive_low;
    logic drive_high;

    always_comb begin
        drive_low  = 1'b0;
        drive_high = 1'b0;
        if (digital_mode && crossbar_enable && !release_pad) begin // see (R01) (R04)
            drive_low  = !out_val;                                   // see (R05) (R06)
            drive_high = out_val && push_pull;                       // see (R05) (R06)
        end
    end

    assign pad_o    = drive_high;
    assign pad_oe_n = !(drive_low || drive_high);
    // pull-up only on digital cells not pulled low, unless globally off
    assign pullup_on = digital_mode && !release_pad && !drive_low  // see (R02) (R07) (R08)
                       && !pullup_global_disable;                  // see (R09)
    // analog cells have no receiver and read zero
    assign read_val = digital_mode && pad_i;                       // see (R03) (R10)

endmodule : port_io_cell

`default_nettype wire

// ---- core/crossbar_decoder.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "port_io_consts.svh"

module crossbar_decoder (
    // requests
    input  wire logic [`PIO_NUM_SLOTS-1:0] slot_en,
    input  wire logic [`PIO_NUM_PINS-1:0]  skip,
    // assignment
    output logic [`PIO_NUM_PINS-1:0]       pin_owned,
    output port_io_pkg::slot_t             pin_slot [`PIO_NUM_PINS]
);

    logic [`PIO_NUM_SLOTS-1:0] used;
    logic                      found;

    // combinational, so a setting change reaches the pads at once
    always_comb begin // see (R19)
        used      = '0;
        found     = 1'b0;
        pin_owned = '0;
        for (int p = 0; p < `PIO_NUM_PINS; p++) begin
            pin_slot[p] = '0;
        end
        // first serial port and can controller sit on fixed pins
        for (int k = 0; k < `PIO_SLOT_FLEX; k++) begin // see (R15)
            if (slot_en[k] && !skip[`PIO_FIXED_BASE_PIN + k]) begin // see (R13)
                pin_owned[`PIO_FIXED_BASE_PIN + k] = 1'b1;
                pin_slot[`PIO_FIXED_BASE_PIN + k]  = port_io_pkg::slot_t'(k);
            end
        end
        // each remaining function takes the lowest free, unskipped pin
        for (int p = 0; p < `PIO_NUM_PINS; p++) begin // see (R12) (R18)
            found = 1'b0;
            if (!skip[p] && !pin_owned[p]) begin // see (R13) (R14)
                for (int k = `PIO_SLOT_FLEX; k < `PIO_NUM_SLOTS; k++) begin
                    if (!found && slot_en[k] && !used[k]) begin
                        found       = 1'b1;
                        used[k]     = 1'b1;
                        pin_owned[p] = 1'b1;
                        pin_slot[p]  = port_io_pkg::slot_t'(k);
                    end
                end
            end
        end
    end

endmodule : crossbar_decoder

`default_nettype wire

// ---- core/port_io_block.sv ----
// What this block does
// (R01) After reset all cells are high impedance with pull-up until crossbar is enabled.
// (R02) Analog pin: pull-up, output driver and input receiver are all off.
// (R03) Reading an analog pin always gives 0.
// (R04) Input mode bit 1 makes the pin digital; output mode picks driver.
// (R05) Push-pull digital pin drives pad high for 1, low for 0.
// (R06) Open-drain never drives high; low for 0, released for 1.
// (R07) A released digital cell keeps its weak pull-up on.
// (R08) Pull-up is off while the cell drives its pad low.
// (R09) Global pull-up disable turns every pull-up off.
// (R10) Reading a digital pin returns the pad level, not the driven value.
// (R11) Pin state is readable in the port latch whatever the crossbar does.
// (R12) Crossbar routes enabled functions to pins by fixed priority.
// (R13) Skipped pins are never claimed by the crossbar.
// (R14) Routed functions land only on pins with skip bit 0.
// (R15) First serial port is on P0.4/P0.5, can controller on P0.6/P0.7.
// (R16) Highest pin is digital only and shared with the debug data line.
// (R17) Reference, crystal input and oscillator output stay on P0.0, P0.2, P0.3.
// (R18) Each remaining function gets the lowest pin neither assigned nor skipped.
// (R19) Ownership follows current settings at once, with no handshake.
`timescale 1ns/1ns
`default_nettype none
`include "port_io_consts.svh"

module port_io_block (
    // clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // axi4-lite write address and data
    input  wire logic [11:0]               awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    // axi4-lite write response
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    // axi4-lite read
    input  wire logic [11:0]               araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    // pads
    input  wire logic [`PIO_NUM_PINS-1:0]  pad_i,
    output logic [`PIO_NUM_PINS-1:0]       pad_o,
    output logic [`PIO_NUM_PINS-1:0]       pad_oe_n,
    output logic [`PIO_NUM_PINS-1:0]       pad_pullup,
    // peripheral functions, one slot each
    input  wire logic [`PIO_NUM_SLOTS-1:0] periph_out,
    input  wire logic [`PIO_NUM_SLOTS-1:0] periph_drive,
    output logic [`PIO_NUM_SLOTS-1:0]      periph_in,
    // dedicated analog users
    input  wire logic                      vref_enable,
    input  wire logic                      ext_osc_enable,
    input  wire logic                      crystal_mode,
    // debug data line on the highest pin
    input  wire logic                      debug_active,
    input  wire logic                      debug_drive,
    input  wire logic                      debug_out,
    output logic                           debug_in
);

    // register state
    logic [39:0] latch_r,    latch_nxt;
    logic [39:0] in_mode_r,  in_mode_nxt;
    logic [39:0] out_mode_r, out_mode_nxt;
    logic [39:0] skip_r,     skip_nxt;
    logic [7:0]  sel_a_r,    sel_a_nxt;
    logic [7:0]  sel_b_r,    sel_b_nxt;
    logic [7:0]  sel_c_r,    sel_c_nxt;
    logic [1:0]  ctrl_r,     ctrl_nxt;

    // bus state
    logic        aw_held_r,  aw_held_nxt;
    logic        w_held_r,   w_held_nxt;
    logic [11:0] waddr_r,    waddr_nxt;
    logic [7:0]  wbyte_r,    wbyte_nxt;
    logic        wlane_r,    wlane_nxt;
    logic        bvalid_r,   bvalid_nxt;
    logic [1:0]  bresp_r,    bresp_nxt;
    logic        rvalid_r,   rvalid_nxt;
    logic [1:0]  rresp_r,    rresp_nxt;
    logic [31:0] rdata_r,    rdata_nxt;

    // pin side
    logic [`PIO_NUM_PINS-1:0]  pin_read;
    logic [`PIO_NUM_PINS-1:0]  dedicated;
    logic [`PIO_NUM_PINS-1:0]  pin_owned;
    port_io_pkg::slot_t        pin_slot [`PIO_NUM_PINS];
    logic [`PIO_NUM_SLOTS-1:0] slot_en;
    logic [39:0]               read_vec;
    logic                      xbar_en;
    logic                      pud;

    assign xbar_en = ctrl_r[`PIO_CTRL_XBAR_BIT];
    assign pud     = ctrl_r[`PIO_CTRL_PUD_BIT];

    function automatic logic port_addr_ok(input logic [11:0] a);
        port_addr_ok = (a[11:7] == 5'h00) && (a[6:4] <= `PIO_PORT_LAST) && (a[1:0] == 2'h0);
    endfunction : port_addr_ok

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = port_addr_ok(a) || a == `PIO_SEL_A_ADDR || a == `PIO_SEL_B_ADDR
                  || a == `PIO_SEL_C_ADDR || a == `PIO_CTRL_ADDR;
    endfunction : addr_ok

    // function enables from the three select registers
    always_comb begin // see (R12)
        slot_en = '0;
        slot_en[`PIO_SLOT_UART +: 2] = {2{sel_a_r[0]}};
        slot_en[`PIO_SLOT_CAN +: 2]  = {2{sel_c_r[0]}};
        slot_en[`PIO_SLOT_SPI +: 4]  = {4{sel_a_r[1]}};
        slot_en[`PIO_SLOT_SMB +: 2]  = {2{sel_a_r[2]}};
        slot_en[`PIO_SLOT_CMP +: 5]  = sel_a_r[7:3];
        for (int c = 0; c < `PIO_PCA_CHANNELS; c++) begin
            slot_en[`PIO_SLOT_PCA + c] = (sel_b_r[2:0] > 3'(c));
        end
        slot_en[`PIO_SLOT_ECI]       = sel_b_r[3];
        slot_en[`PIO_SLOT_T0]        = sel_b_r[4];
        slot_en[`PIO_SLOT_T1]        = sel_b_r[5];
        slot_en[`PIO_SLOT_LIN +: 2]  = {2{sel_c_r[1]}};
        if (!xbar_en) begin
            slot_en = '0;
        end
    end

    // fixed analog users keep their pins off crossbar and drivers
    always_comb begin // see (R17)
        dedicated = '0;
        dedicated[`PIO_VREF_PIN]    = vref_enable;
        dedicated[`PIO_XTAL_IN_PIN] = ext_osc_enable && crystal_mode;
        dedicated[`PIO_OSC_OUT_PIN] = ext_osc_enable;
    end

    crossbar_decoder u_xbar (
        .slot_en   (slot_en),
        .skip      (skip_r[`PIO_NUM_PINS-1:0] | dedicated), // see (R13) (R17)
        .pin_owned (pin_owned),
        .pin_slot  (pin_slot)
    );

    generate
        for (genvar p = 0; p < `PIO_NUM_PINS; p++) begin : g_pin
            logic out_val;
            logic push_pull;
            logic digital;
            logic cell_xbar;

            always_comb begin
                digital   = in_mode_r[p];
                push_pull = out_mode_r[p];
                cell_xbar = xbar_en;
                if (pin_owned[p]) begin
                    // input functions drive 1, which releases only open-drain pins
                    out_val = periph_drive[pin_slot[p]] ? periph_out[pin_slot[p]] : 1'b1;
                end else begin
                    out_val = latch_r[p];
                end
                if (p == `PIO_DEBUG_PIN) begin
                    digital = 1'b1; // see (R16)
                    if (debug_active) begin
                        out_val   = debug_drive ? debug_out : 1'b1;
                        push_pull = debug_drive;
                        cell_xbar = 1'b1;
                    end
                end
            end

            port_io_cell u_cell (
                .digital_mode          (digital),
                .push_pull             (push_pull),
                .crossbar_enable       (cell_xbar),
                .pullup_global_disable (pud),
                .release_pad           (dedicated[p]),
                .out_val               (out_val),
                .pad_i                 (pad_i[p]),
                .pad_o                 (pad_o[p]),
                .pad_oe_n              (pad_oe_n[p]),
                .pullup_on             (pad_pullup[p]),
                .read_val              (pin_read[p])
            );
        end
    endgenerate

    assign debug_in = pin_read[`PIO_DEBUG_PIN];

    // peripherals read their pad; idle high when unassigned
    always_comb begin
        periph_in = '1;
        for (int p = 0; p < `PIO_NUM_PINS; p++) begin
            if (pin_owned[p]) begin
                periph_in[pin_slot[p]] = pin_read[p];
            end
        end
    end

    // latch reads show the pad state, whoever owns the pin
    assign read_vec = {7'h00, pin_read}; // see (R10) (R11)

    assign awready = !aw_held_r && !bvalid_r;
    assign wready  = !w_held_r && !bvalid_r;
    assign arready = !rvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign rvalid  = rvalid_r;
    assign rresp   = rresp_r;
    assign rdata   = rdata_r;

    always_comb begin
        latch_nxt    = latch_r;
        in_mode_nxt  = in_mode_r;
        out_mode_nxt = out_mode_r;
        skip_nxt     = skip_r;
        sel_a_nxt    = sel_a_r;
        sel_b_nxt    = sel_b_r;
        sel_c_nxt    = sel_c_r;
        ctrl_nxt     = ctrl_r;
        aw_held_nxt  = aw_held_r;
        w_held_nxt   = w_held_r;
        waddr_nxt    = waddr_r;
        wbyte_nxt    = wbyte_r;
        wlane_nxt    = wlane_r;
        bvalid_nxt   = bvalid_r;
        bresp_nxt    = bresp_r;
        rvalid_nxt   = rvalid_r;
        rresp_nxt    = rresp_r;
        rdata_nxt    = rdata_r;

        if (awvalid && awready) begin
            aw_held_nxt = 1'b1;
            waddr_nxt   = awaddr;
        end
        if (wvalid && wready) begin
            w_held_nxt = 1'b1;
            wbyte_nxt  = wdata[7:0];
            wlane_nxt  = wstrb[0];
        end
        if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end

        // commit once both halves are held; only byte lane 0 carries data
        if (aw_held_r && w_held_r && !bvalid_r) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = addr_ok(waddr_r) ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
            if (wlane_r && port_addr_ok(waddr_r)) begin
                case (port_io_pkg::reg_kind_t'(waddr_r[3:2]))
                    port_io_pkg::KIND_LATCH:    latch_nxt[{waddr_r[6:4], 3'h0} +: 8]    = wbyte_r;
                    port_io_pkg::KIND_IN_MODE:  in_mode_nxt[{waddr_r[6:4], 3'h0} +: 8]  = wbyte_r;
                    port_io_pkg::KIND_OUT_MODE: out_mode_nxt[{waddr_r[6:4], 3'h0} +: 8] = wbyte_r;
                    port_io_pkg::KIND_SKIP:     skip_nxt[{waddr_r[6:4], 3'h0} +: 8]     = wbyte_r;
                    default: ;
                endcase
            end else if (wlane_r) begin
                case (waddr_r)
                    `PIO_SEL_A_ADDR: sel_a_nxt = wbyte_r;
                    `PIO_SEL_B_ADDR: sel_b_nxt = wbyte_r;
                    `PIO_SEL_C_ADDR: sel_c_nxt = wbyte_r;
                    `PIO_CTRL_ADDR:  ctrl_nxt  = wbyte_r[1:0];
                    default: ;
                endcase
            end
        end

        // bits beyond the last pin do not exist and read zero
        latch_nxt    = latch_nxt & `PIO_PIN_MASK;
        in_mode_nxt  = in_mode_nxt & `PIO_PIN_MASK;
        out_mode_nxt = out_mode_nxt & `PIO_PIN_MASK;
        skip_nxt     = skip_nxt & `PIO_PIN_MASK;

        if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = 32'h0000_0000;
            rresp_nxt  = addr_ok(araddr) ? `PIO_RESP_OKAY : `PIO_RESP_SLVERR;
            if (port_addr_ok(araddr)) begin
                case (port_io_pkg::reg_kind_t'(araddr[3:2]))
                    port_io_pkg::KIND_LATCH:    rdata_nxt[7:0] = read_vec[{araddr[6:4], 3'h0} +: 8];
                    port_io_pkg::KIND_IN_MODE:  rdata_nxt[7:0] = in_mode_r[{araddr[6:4], 3'h0} +: 8];
                    port_io_pkg::KIND_OUT_MODE: rdata_nxt[7:0] = out_mode_r[{araddr[6:4], 3'h0} +: 8];
                    port_io_pkg::KIND_SKIP:     rdata_nxt[7:0] = skip_r[{araddr[6:4], 3'h0} +: 8];
                    default: ;
                endcase
            end else begin
                case (araddr)
                    `PIO_SEL_A_ADDR: rdata_nxt[7:0] = sel_a_r;
                    `PIO_SEL_B_ADDR: rdata_nxt[7:0] = sel_b_r;
                    `PIO_SEL_C_ADDR: rdata_nxt[7:0] = sel_c_r;
                    `PIO_CTRL_ADDR:  rdata_nxt[1:0] = ctrl_r;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_r    <= `PIO_LATCH_RST & `PIO_PIN_MASK;
            in_mode_r  <= `PIO_IN_MODE_RST & `PIO_PIN_MASK; // see (R01)
            out_mode_r <= `PIO_OUT_MODE_RST;
            skip_r     <= `PIO_SKIP_RST;
            sel_a_r    <= `PIO_SEL_RST;
            sel_b_r    <= `PIO_SEL_RST;
            sel_c_r    <= `PIO_SEL_RST;
            ctrl_r     <= `PIO_CTRL_RST; // see (R01)
            aw_held_r  <= 1'b0;
            w_held_r   <= 1'b0;
            waddr_r    <= 12'h000;
            wbyte_r    <= 8'h00;
            wlane_r    <= 1'b0;
            bvalid_r   <= 1'b0;
            bresp_r    <= `PIO_RESP_OKAY;
            rvalid_r   <= 1'b0;
            rresp_r    <= `PIO_RESP_OKAY;
            rdata_r    <= 32'h0000_0000;
        end else begin
            latch_r    <= latch_nxt;
            in_mode_r  <= in_mode_nxt;
            out_mode_r <= out_mode_nxt;
            skip_r     <= skip_nxt;
            sel_a_r    <= sel_a_nxt;
            sel_b_r    <= sel_b_nxt;
            sel_c_r    <= sel_c_nxt;
            ctrl_r     <= ctrl_nxt;
            aw_held_r  <= aw_held_nxt;
            w_held_r   <= w_held_nxt;
            waddr_r    <= waddr_nxt;
            wbyte_r    <= wbyte_nxt;
            wlane_r    <= wlane_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            rvalid_r   <= rvalid_nxt;
            rresp_r    <= rresp_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

endmodule : port_io_block

`default_nettype wire

// ---- test/port_io_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "port_io_consts.svh"

module port_io_checker (
    // clock and reset
    input wire logic                     aclk,
    input wire logic                     aresetn,
    // register bus
    input wire logic                     awready,
    input wire logic                     wready,
    input wire logic [1:0]               bresp,
    input wire logic                     bvalid,
    input wire logic                     bready,
    input wire logic                     arvalid,
    input wire logic                     arready,
    input wire logic [31:0]              rdata,
    input wire logic                     rvalid,
    input wire logic                     rready,
    // pads and dedicated users
    input wire logic [`PIO_NUM_PINS-1:0] pad_i,
    input wire logic [`PIO_NUM_PINS-1:0] pad_o,
    input wire logic [`PIO_NUM_PINS-1:0] pad_oe_n,
    input wire logic [`PIO_NUM_PINS-1:0] pad_pullup,
    input wire logic                     vref_enable,
    input wire logic                     ext_osc_enable,
    input wire logic                     debug_in
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // pin 32 may differ out of reset; pins 0..3 may differ in pull-up only
    a_reset_idle: assert property ($past(!aresetn) |-> (&pad_oe_n[31:0]) && (&pad_pullup[31:4]))
        else $error("pads not idle after reset");
    a_low_no_pull: assert property ((~pad_oe_n & ~pad_o & pad_pullup) == '0)
        else $error("pull-up on while driving low");
    a_vref_pin_free: assert property (vref_enable |-> pad_oe_n[0] && !pad_pullup[0])
        else $error("reference pin not released");
    a_osc_pin_free: assert property (ext_osc_enable |-> pad_oe_n[3] && !pad_pullup[3])
        else $error("oscillator pin not released");
    a_debug_reads_pad: assert property (debug_in == pad_i[32])
        else $error("debug read differs from pad");
    a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_data_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered in one cycle");
    a_busy_refuse: assert property ((rvalid |-> !arready) and (bvalid |-> !awready && !wready))
        else $error("request taken while answer pending");
endmodule : port_io_checker

bind port_io_block port_io_checker u_checker (.*);

`default_nettype wire

// ---- test/pad_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "port_io_consts.svh"

module pad_partner (
    // clock
    input  wire logic                     aclk,
    // cell side
    input  wire logic [`PIO_NUM_PINS-1:0] pad_o,
    input  wire logic [`PIO_NUM_PINS-1:0] pad_oe_n,
    input  wire logic [`PIO_NUM_PINS-1:0] pad_pullup,
    // far-side drivers set by the bench
    input  wire logic [`PIO_NUM_PINS-1:0] ext_en,
    input  wire logic [`PIO_NUM_PINS-1:0] ext_val,
    // resolved level
    output logic      [`PIO_NUM_PINS-1:0] pad_i
);
    logic [`PIO_NUM_PINS-1:0] float_r = '0;

    // an undriven, unpulled pad toggles so a stale level never passes
    always @(posedge aclk) float_r <= ~float_r;

    assign pad_i = (~pad_oe_n & pad_o) | (pad_oe_n & ext_en & ext_val)
                 | (pad_oe_n & ~ext_en & (pad_pullup | float_r));
endmodule : pad_partner

`default_nettype wire

// ---- test/port_io_block_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "port_io_consts.svh"

module port_io_block_tb_top;
    logic                      aclk = 1'b0, aresetn = 1'b0;
    logic [11:0]               awaddr = 12'h000, araddr = 12'h000;
    logic [31:0]               wdata = 32'h0, rdata;
    logic [3:0]                wstrb = 4'hF;
    logic                      awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic                      awready, wready, bvalid, arready, rvalid;
    logic [1:0]                bresp, rresp;
    logic [`PIO_NUM_PINS-1:0]  pad_i, pad_o, pad_oe_n, pad_pullup;
    logic [`PIO_NUM_PINS-1:0]  ext_en = '0, ext_val = '0;
    logic [`PIO_NUM_SLOTS-1:0] periph_out = '0, periph_drive = '0, periph_in;
    logic                      vref_enable = 1'b0, ext_osc_enable = 1'b0, crystal_mode = 1'b0;
    logic                      debug_active = 1'b0, debug_drive = 1'b0, debug_out = 1'b0, debug_in;
    int                        fail_count = 0, cmp_count = 0;

    always #25 aclk = ~aclk;

    port_io_block dut (.*);
    pad_partner u_partner (.*);

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // bready rises only after bvalid, so the hold is exercised
    task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
        logic aw_ok, w_ok, b_ok, b_seen;
        logic [1:0] resp;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_seen = bvalid;
            b_ok = bvalid && bready;
            resp = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            bready <= b_seen && !b_ok;
        end while (!b_ok);
        check(40'(resp), 40'(`PIO_RESP_OKAY));
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
        logic ar_ok, r_ok, r_seen;
        logic [31:0] d;
        logic [1:0] resp;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_seen = rvalid;
            r_ok = rvalid && rready;
            d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
            rready <= r_seen && !r_ok;
        end while (!r_ok);
        check(40'(d), 40'(exp));
        check(40'(resp), 40'(er));
    endtask : axi_read

    initial begin
        #(4000 * 50);
        fail_count++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check(40'(pad_oe_n), 40'h01_FFFF_FFFF);
        check(40'(pad_pullup), 40'h01_FFFF_FFFF);
        axi_read(12'h000, 8'hFF, 2'h0);
        axi_read(12'h004, 8'hFF, 2'h0);
        axi_read(12'h008, 8'h00, 2'h0);
        axi_read(12'h00C, 8'h00, 2'h0);
        axi_read(12'h044, 8'h01, 2'h0);
        axi_read(12'h100, 8'h00, `PIO_RESP_SLVERR);
        // port 1 push-pull, crossbar still off
        axi_write(12'h018, 8'hFF);
        axi_write(12'h010, 8'h00);
        @(negedge aclk);
        check(40'(pad_oe_n[15:8]), 40'hFF);
        axi_write(`PIO_CTRL_ADDR, 8'h01);
        @(negedge aclk);
        check(40'(pad_oe_n[15:8]), 40'h00);
        check(40'(pad_pullup[15:8]), 40'h00);
        axi_write(12'h010, 8'hA5);
        @(negedge aclk);
        check(40'(pad_o[15:8]), 40'hA5);
        axi_read(12'h010, 8'hA5, 2'h0);
        // open-drain, far side pulling low
        axi_write(12'h018, 8'h00);
        axi_write(12'h010, 8'h0F);
        @(posedge aclk);
        ext_en[15:8] <= 8'hFF;
        @(negedge aclk);
        check(40'(pad_oe_n[15:8]), 40'h0F);
        check(40'(pad_pullup[15:8]), 40'h0F);
        axi_read(12'h010, 8'h00, 2'h0);
        axi_write(`PIO_CTRL_ADDR, 8'h03);
        @(negedge aclk);
        check(40'(pad_pullup[15:8]), 40'h00);
        axi_write(`PIO_CTRL_ADDR, 8'h01);
        // analog pins read 0 with pads high
        @(posedge aclk);
        ext_val[15:8] <= 8'hFF;
        axi_write(12'h014, 8'h00);
        @(negedge aclk);
        check(40'(pad_oe_n[15:8]), 40'hFF);
        check(40'(pad_pullup[15:8]), 40'h00);
        axi_read(12'h010, 8'h00, 2'h0);
        // crossbar: sysclk, serial port, can
        @(posedge aclk);
        ext_en <= 33'h0_0000_0020;
        periph_drive <= 26'h000_4005;
        axi_write(`PIO_SEL_A_ADDR, 8'h81);
        axi_write(`PIO_SEL_C_ADDR, 8'h01);
        @(negedge aclk);
        check(40'(pad_oe_n[7:0]), 40'hAE);
        check(40'(periph_in[1]), 40'h0);
        axi_write(12'h00C, 8'h03);
        @(negedge aclk);
        check(40'(pad_oe_n[7:0]), 40'hAB);
        axi_write(12'h00C, 8'h13);
        @(negedge aclk);
        check(40'(pad_oe_n[4]), 40'h1);
        axi_write(12'h00C, 8'h00);
        @(posedge aclk);
        vref_enable <= 1'b1;
        ext_osc_enable <= 1'b1;
        crystal_mode <= 1'b1;
        @(negedge aclk);
        check(40'(pad_oe_n[3:0]), 40'hD);
        check(40'(pad_pullup[3:0]), 40'h0);
        @(posedge aclk);
        debug_active <= 1'b1;
        debug_drive <= 1'b1;
        @(negedge aclk);
        check(40'({pad_oe_n[32], pad_o[32], debug_in}), 40'h0);
        wrap_up();
    end
endmodule : port_io_block_tb_top

`default_nettype wire
